// File: spl_splitter_control_registers.v
// Behaviour
// - Config bit 7 low puts receive equalizer and output drivers in standby.
// - Config bits 6 to 3 enable output ports one to four.
// - Config bit 2 enables the source connection detector; default on.
// - With detector on, a port whose sink plug input is low stays inactive.
// - With detector on and all sinks low, input termination is switched off.
// - Receiver bit 7 high disconnects the input pull-down resistors.
// - Receiver bit 6 ties termination bias to supply when high, ground when low.
// - Receiver bit 5 low leaves bias to the pin; high lets bit 6 act.
// - Receiver bits 4 to 2 select equalization gain; 000 is 0 dB.
// - Port byte bit 7 selects open-drain (0) or double-terminated (1) output.
// - Port byte bits 6 to 4 set pre-emphasis; 1xx is strongest, 750 mVpp.
// - Port byte bits 3 to 2 set output swing around 500 mV.
// - Port byte bits 1 to 0 set output slew rate.
// - Hot-plug bit 7 high inverts the source plug output, low passes it.
// - Hot-plug bits 3 to 0 read live sink plug levels, read-only.
// - Registers are reached over a two-wire serial bus up to 400 kb/s.
// - Mode pin high gives register control; low leaves fields without effect.
`timescale 1ns/10ps
`include "spl_defines.vh"
`default_nettype none

module spl_splitter_control_registers (
   // Clock and reset.
   input wire clk_in,
   input wire reset_n_in,
   // Two-wire serial bus; data is open drain.
   input wire scl_in,
   input wire sda_in,
   output wire sda_out_out,
   output reg sda_oe_n_out,
   input wire [3:0] bus_addr_sel_in,
   // Control pins.
   input wire control_mode_select_pin_in,
   input wire bias_pin_select_in,
   // Hot-plug pins.
   input wire [3:0] sink_plug_detect_input_in,
   output reg source_plug_detect_output_out,
   // Receive side controls.
   output reg standby_out,
   output reg rx_eq_power_down_out,
   output reg rx_term_enable_out,
   output reg rx_pulldown_connect_out,
   output reg rx_bias_vdd_out,
   output reg [2:0] rx_eq_code_out,
   // Output port controls, port one in the low bits.
   output wire [3:0] port_active_out,
   output wire [3:0] port_double_term_out,
   output wire [11:0] port_emph_out,
   output wire [3:0] port_high_emph_out,
   output wire [7:0] port_swing_out,
   output wire [7:0] port_slew_out
);

   // Serial engine states.
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_ACK_A = 4'h2;
   localparam [3:0] ST_REG = 4'h3;
   localparam [3:0] ST_ACK_W = 4'h4;
   localparam [3:0] ST_WDATA = 4'h5;
   localparam [3:0] ST_RDATA = 4'h6;
   localparam [3:0] ST_ACK_R = 4'h7;

   reg [3:0] state_q;
   reg [2:0] cnt_q;
   reg done_q;
   reg [7:0] sh_q;
   reg rw_q;
   reg nack_q;
   reg [7:0] ptr_q;
   reg [7:0] cfg_q;
   reg [7:0] rx_q;
   reg [7:0] tx_q [0:3];
   reg hp_pol_q;
   integer i;

   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire [7:0] rd_now;
   wire addr_hit;
   wire reg_mode;
   wire [7:0] eff_cfg;
   wire [7:0] eff_rx;
   wire eff_pol;
   wire detect_on;
   wire any_sink;
   wire [3:0] port_want;

   // Read view of one byte of the bank; unmapped offsets read zero.
   function [7:0] rd_byte;
      input [7:0] a;
      begin
         case (a)
            `SPL_OFS_CFG: rd_byte = cfg_q;
            `SPL_OFS_RX: rd_byte = rx_q;
            `SPL_OFS_TX1: rd_byte = tx_q[0];
            `SPL_OFS_TX2: rd_byte = tx_q[1];
            `SPL_OFS_TX3: rd_byte = tx_q[2];
            `SPL_OFS_TX4: rd_byte = tx_q[3];
            // Live sink levels in the low nibble; bits 6 to 4 read zero.
            `SPL_OFS_HP: rd_byte = {hp_pol_q, 3'h0, sink_plug_detect_input_in};
            default: rd_byte = 8'h00;
         endcase
      end
   endfunction

   // Select between register fields and power-up values by the mode pin.
   function [7:0] eff_byte;
      input [7:0] stored;
      input [7:0] fallback;
      begin
         eff_byte = reg_mode ? stored : fallback;
      end
   endfunction

   // Pointer after one data byte; it runs on past the map rather than wrapping.
   function [7:0] ptr_step;
      input [7:0] p;
      begin
         ptr_step = p + 8'h01;
      end
   endfunction

   // Bit counter step within a byte; it wraps back to zero after the eighth bit.
   function [2:0] cnt_step;
      input [2:0] c;
      begin
         cnt_step = c + 3'h1;
      end
   endfunction

   // High when the bit being taken is the eighth of its byte.
   function last_bit;
      input [2:0] c;
      begin
         last_bit = (c == 3'h7);
      end
   endfunction

   // Line edge and start/stop detection.
   spl_line_sampler u_sampler (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_rise_out(scl_rise),
      .scl_fall_out(scl_fall),
      .start_out(bus_start),
      .stop_out(bus_stop)
   );

   // The data line is only ever pulled low; release lets it float high.
   assign sda_out_out = 1'b0;
   assign rd_now = rd_byte(ptr_q);
   assign addr_hit = (sh_q[7:1] == {`SPL_DEV_ADDR_HI, bus_addr_sel_in});

   // Serial engine: bits are taken on the clock rise, driven after the fall.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ST_IDLE;
         cnt_q <= 3'h0;
         done_q <= 1'b0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         ptr_q <= 8'h00;
         sda_oe_n_out <= 1'b1;
         cfg_q <= `SPL_RST_CFG;
         rx_q <= `SPL_RST_RX;
         for (i = 0; i < 4; i = i + 1) begin
            tx_q[i] <= `SPL_RST_TX;
         end
         hp_pol_q <= 1'b0;
      end else if (bus_start) begin
         // A start, repeated or not, always begins a new address byte.
         state_q <= ST_ADDR;
         cnt_q <= 3'h0;
         done_q <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end else if (bus_stop) begin
         state_q <= ST_IDLE;
         done_q <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end else if (scl_rise) begin
         case (state_q)
            ST_ADDR, ST_REG, ST_WDATA: begin
               sh_q <= {sh_q[6:0], sda_in};
               cnt_q <= cnt_step(cnt_q);
               done_q <= last_bit(cnt_q);
            end
            ST_RDATA: begin
               cnt_q <= cnt_step(cnt_q);
               done_q <= last_bit(cnt_q);
            end
            ST_ACK_R: begin
               // A high level in the acknowledge slot ends the read.
               nack_q <= sda_in;
            end
            default: begin
               done_q <= done_q;
            end
         endcase
      end else if (scl_fall) begin
         done_q <= 1'b0;
         cnt_q <= 3'h0;
         case (state_q)
            ST_ADDR: begin
               if (done_q && addr_hit) begin
                  rw_q <= sh_q[0];
                  sda_oe_n_out <= 1'b0;
                  state_q <= ST_ACK_A;
               end else if (done_q) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q;
               end
            end
            ST_ACK_A: begin
               if (rw_q) begin
                  sh_q <= rd_now;
                  sda_oe_n_out <= rd_now[7];
                  state_q <= ST_RDATA;
               end else begin
                  sda_oe_n_out <= 1'b1;
                  state_q <= ST_REG;
               end
            end
            ST_REG: begin
               if (done_q) begin
                  ptr_q <= sh_q;
                  sda_oe_n_out <= 1'b0;
                  state_q <= ST_ACK_W;
               end else begin
                  cnt_q <= cnt_q;
               end
            end
            ST_WDATA: begin
               if (done_q) begin
                  // Reserved byte and read-only bits keep their value.
                  case (ptr_q)
                     `SPL_OFS_CFG: cfg_q <= sh_q;
                     `SPL_OFS_RX: rx_q <= sh_q;
                     `SPL_OFS_TX1: tx_q[0] <= sh_q;
                     `SPL_OFS_TX2: tx_q[1] <= sh_q;
                     `SPL_OFS_TX3: tx_q[2] <= sh_q;
                     `SPL_OFS_TX4: tx_q[3] <= sh_q;
                     `SPL_OFS_HP: hp_pol_q <= sh_q[`SPL_HP_POL_BIT];
                     default: hp_pol_q <= hp_pol_q;
                  endcase
                  ptr_q <= ptr_step(ptr_q);
                  sda_oe_n_out <= 1'b0;
                  state_q <= ST_ACK_W;
               end else begin
                  cnt_q <= cnt_q;
               end
            end
            ST_ACK_W: begin
               sda_oe_n_out <= 1'b1;
               state_q <= ST_WDATA;
            end
            ST_RDATA: begin
               if (done_q) begin
                  sda_oe_n_out <= 1'b1;
                  ptr_q <= ptr_step(ptr_q);
                  nack_q <= 1'b0;
                  state_q <= ST_ACK_R;
               end else begin
                  sda_oe_n_out <= sh_q[6];
                  sh_q <= {sh_q[6:0], 1'b0};
                  cnt_q <= cnt_q;
               end
            end
            ST_ACK_R: begin
               if (nack_q) begin
                  state_q <= ST_IDLE;
               end else begin
                  sh_q <= rd_now;
                  sda_oe_n_out <= rd_now[7];
                  state_q <= ST_RDATA;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Effective settings: register fields only under register control.
   assign reg_mode = control_mode_select_pin_in;
   assign eff_cfg = eff_byte(cfg_q, `SPL_RST_CFG);
   assign eff_rx = eff_byte(rx_q, `SPL_RST_RX);
   assign eff_pol = reg_mode & hp_pol_q;
   assign detect_on = eff_cfg[`SPL_CFG_DETECT_BIT];
   assign any_sink = |sink_plug_detect_input_in;

   // Port wanted: selected, not in standby, and connected when detecting.
   assign port_want = {eff_cfg[`SPL_CFG_PORT4_BIT],
                       eff_cfg[`SPL_CFG_PORT4_BIT + 1],
                       eff_cfg[`SPL_CFG_PORT1_BIT - 1],
                       eff_cfg[`SPL_CFG_PORT1_BIT]}
                      & {4{eff_cfg[`SPL_CFG_NORMAL_BIT]}}
                      & (sink_plug_detect_input_in | {4{~detect_on}});

   // Receive side and hot-plug outputs, registered.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         standby_out <= 1'b0;
         rx_eq_power_down_out <= 1'b0;
         rx_term_enable_out <= 1'b0;
         rx_pulldown_connect_out <= 1'b1;
         rx_bias_vdd_out <= 1'b0;
         rx_eq_code_out <= 3'h0;
         source_plug_detect_output_out <= 1'b0;
      end else begin
         standby_out <= ~eff_cfg[`SPL_CFG_NORMAL_BIT];
         rx_eq_power_down_out <= ~eff_cfg[`SPL_CFG_NORMAL_BIT];
         rx_term_enable_out <= ~(detect_on & ~any_sink);
         rx_pulldown_connect_out <= ~eff_rx[`SPL_RX_PD_OFF_BIT];
         // Bias follows the pin unless the register takes over.
         if (eff_rx[`SPL_RX_BIAS_REG_BIT]) begin
            rx_bias_vdd_out <= eff_rx[`SPL_RX_BIAS_VDD_BIT];
         end else begin
            rx_bias_vdd_out <= bias_pin_select_in;
         end
         rx_eq_code_out <= eff_rx[`SPL_RX_EQ_MSB:`SPL_RX_EQ_LSB];
         // Any connected sink raises the source level, then polarity applies.
         source_plug_detect_output_out <= any_sink ^ eff_pol;
      end
   end

   // One driver decode per output port.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_port
         spl_port_drive u_drive (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .settings_in(eff_byte(tx_q[g], `SPL_RST_TX)),
            .enable_in(port_want[g]),
            .active_out(port_active_out[g]),
            .double_term_out(port_double_term_out[g]),
            .emph_out(port_emph_out[3*g+2:3*g]),
            .high_emph_out(port_high_emph_out[g]),
            .swing_out(port_swing_out[2*g+1:2*g]),
            .slew_out(port_slew_out[2*g+1:2*g])
         );
      end
   endgenerate

endmodule

`default_nettype wire

// File: spl_defines.vh
`ifndef SPL_DEFINES_VH
`define SPL_DEFINES_VH

// Register offsets within the eight-byte bank.
`define SPL_OFS_CFG 8'h00
`define SPL_OFS_RX 8'h01
`define SPL_OFS_TX1 8'h02
`define SPL_OFS_TX2 8'h03
`define SPL_OFS_TX3 8'h04
`define SPL_OFS_TX4 8'h05
`define SPL_OFS_HP 8'h06
`define SPL_OFS_RSVD 8'h07

// Power-up values.
`define SPL_RST_CFG 8'hff
`define SPL_RST_RX 8'h00
`define SPL_RST_TX 8'h00
`define SPL_RST_HP 8'h00

// Field positions of device_config.
`define SPL_CFG_NORMAL_BIT 7
`define SPL_CFG_PORT1_BIT 6
`define SPL_CFG_PORT4_BIT 3
`define SPL_CFG_DETECT_BIT 2

// Field positions of receiver_settings.
`define SPL_RX_PD_OFF_BIT 7
`define SPL_RX_BIAS_VDD_BIT 6
`define SPL_RX_BIAS_REG_BIT 5
`define SPL_RX_EQ_MSB 4
`define SPL_RX_EQ_LSB 2

// Field positions of each port output settings byte.
`define SPL_TX_DTERM_BIT 7
`define SPL_TX_EMPH_MSB 6
`define SPL_TX_EMPH_LSB 4
`define SPL_TX_SWING_MSB 3
`define SPL_TX_SWING_LSB 2
`define SPL_TX_SLEW_MSB 1
`define SPL_TX_SLEW_LSB 0

// Field positions of hot_plug_control_status.
`define SPL_HP_POL_BIT 7
`define SPL_HP_SINK_MSB 3
`define SPL_HP_SINK_LSB 0

// Fixed upper three bits of the seven-bit bus address.
`define SPL_DEV_ADDR_HI 3'h5

`endif

// File: spl_line_sampler.v
`timescale 1ns/10ps
`default_nettype none

module spl_line_sampler (
   // Clock and reset.
   input wire clk_in,
   input wire reset_n_in,
   // Bus lines as seen on the pins.
   input wire scl_in,
   input wire sda_in,
   // Bus events, one cycle each.
   output wire scl_rise_out,
   output wire scl_fall_out,
   output wire start_out,
   output wire stop_out
);

   reg scl_q;
   reg sda_q;

   // Previous line levels; an idle bus rests high.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // A data edge while the clock stays high marks start or stop.
   assign scl_rise_out = scl_in & ~scl_q;
   assign scl_fall_out = ~scl_in & scl_q;
   assign start_out = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_out = scl_in & scl_q & ~sda_q & sda_in;

endmodule

`default_nettype wire

// File: spl_port_drive.v
`timescale 1ns/10ps
`include "spl_defines.vh"
`default_nettype none

module spl_port_drive (
   // Clock and reset.
   input wire clk_in,
   input wire reset_n_in,
   // Effective settings byte and gating for this port.
   input wire [7:0] settings_in,
   input wire enable_in,
   // Decoded driver controls.
   output reg active_out,
   output reg double_term_out,
   output reg [2:0] emph_out,
   output reg high_emph_out,
   output reg [1:0] swing_out,
   output reg [1:0] slew_out
);

   // Registered decode of one output port's driver controls.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         active_out <= 1'b0;
         double_term_out <= 1'b0;
         emph_out <= 3'h0;
         high_emph_out <= 1'b0;
         swing_out <= 2'h0;
         slew_out <= 2'h0;
      end else begin
         active_out <= enable_in;
         double_term_out <= settings_in[`SPL_TX_DTERM_BIT];
         emph_out <= settings_in[`SPL_TX_EMPH_MSB:`SPL_TX_EMPH_LSB];
         // Any code 1xx selects the strongest setting with a 750 mVpp swing.
         high_emph_out <= settings_in[`SPL_TX_EMPH_MSB];
         swing_out <= settings_in[`SPL_TX_SWING_MSB:`SPL_TX_SWING_LSB];
         slew_out <= settings_in[`SPL_TX_SLEW_MSB:`SPL_TX_SLEW_LSB];
      end
   end

endmodule

`default_nettype wire

// File: spl_checker_sva.sv
`timescale 1ns/10ps
`default_nettype none

module spl_checker_sva (
   // Clock and reset.
   input wire clk_in,
   input wire reset_n_in,
   // Watched bus and control pins.
   input wire scl_in,
   input wire sda_out_out,
   input wire sda_oe_n_out,
   input wire control_mode_select_pin_in,
   input wire bias_pin_select_in,
   input wire [3:0] sink_plug_detect_input_in,
   // Watched settings outputs.
   input wire standby_out,
   input wire rx_eq_power_down_out,
   input wire rx_term_enable_out,
   input wire rx_pulldown_connect_out,
   input wire rx_bias_vdd_out,
   input wire [2:0] rx_eq_code_out,
   input wire [3:0] port_active_out,
   input wire [11:0] port_emph_out,
   input wire [3:0] port_high_emph_out,
   input wire [7:0] port_swing_out,
   input wire [7:0] port_slew_out
);
   // Every check runs on the bank clock and rests during reset.
   default clocking spl_cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   a_standby_pair: assert property (rx_eq_power_down_out == standby_out)
      else $error("Equalizer power-down differs from standby.");
   a_standby_quiet: assert property (standby_out [*2] |-> port_active_out == 4'h0)
      else $error("A port is active in standby.");
   a_detect_gate: assert property ((!rx_term_enable_out) [*2] |-> port_active_out == 4'h0)
      else $error("A port is active with no sink present.");
   a_term_on: assert property ((|sink_plug_detect_input_in) [*2] |=> rx_term_enable_out)
      else $error("Termination off while a sink is present.");
   a_pin_mode_rx: assert property ((!control_mode_select_pin_in) [*2] |=>
      !standby_out && rx_pulldown_connect_out && rx_eq_code_out == 3'h0)
      else $error("Receive controls not at power-up values in pin mode.");
   a_pin_mode_tx: assert property ((!control_mode_select_pin_in) [*3] |=>
      port_emph_out == 12'h000 && port_swing_out == 8'h00 && port_slew_out == 8'h00)
      else $error("Port controls not at power-up values in pin mode.");
   a_bias_pin: assert property ((!control_mode_select_pin_in && $stable(bias_pin_select_in)) [*3]
      |-> rx_bias_vdd_out == bias_pin_select_in)
      else $error("Bias does not follow its pin.");
   a_high_emph: assert property (port_high_emph_out ==
      {port_emph_out[11], port_emph_out[8], port_emph_out[5], port_emph_out[2]})
      else $error("Strong emphasis flag differs from code.");
   a_sda_scl_low: assert property (!$stable(sda_oe_n_out) |-> !scl_in && sda_out_out == 1'b0)
      else $error("Data line changed while clock high.");
endmodule

bind spl_splitter_control_registers spl_checker_sva spl_checker_sva_inst (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in), .sda_out_out(sda_out_out),
   .sda_oe_n_out(sda_oe_n_out), .control_mode_select_pin_in(control_mode_select_pin_in),
   .bias_pin_select_in(bias_pin_select_in), .sink_plug_detect_input_in(sink_plug_detect_input_in),
   .standby_out(standby_out), .rx_eq_power_down_out(rx_eq_power_down_out),
   .rx_term_enable_out(rx_term_enable_out), .rx_pulldown_connect_out(rx_pulldown_connect_out),
   .rx_bias_vdd_out(rx_bias_vdd_out), .rx_eq_code_out(rx_eq_code_out), .port_active_out(port_active_out),
   .port_emph_out(port_emph_out), .port_high_emph_out(port_high_emph_out), .port_swing_out(port_swing_out),
   .port_slew_out(port_slew_out)
);

`default_nettype wire

// File: spl_host_model.sv
`timescale 1ns/10ps
`include "spl_defines.vh"
`default_nettype none

module spl_host_model (
   // Clock and wire level.
   input wire logic clk_in,
   input wire logic sda_in,
   // Bus lines driven by the host.
   output var logic scl_out,
   output var logic sda_low_out
);
   logic [6:0] dev_addr;

   // Lines idle high; the address matches the bench's select pins.
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
      dev_addr = {`SPL_DEV_ADDR_HI, 4'h9};
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   // Data moves only while the clock is low; the clock stays high four cycles and low five.
   task automatic put_bit(input logic b, output logic s);
      sda_low_out = ~b;
      tick(4);
      scl_out = 1'b1;
      tick(4);
      s = sda_in;
      scl_out = 1'b0;
      tick(1);
   endtask

   // Start or repeated start: data falls while the clock is high.
   task automatic bus_start;
      sda_low_out = 1'b0;
      tick(4);
      scl_out = 1'b1;
      tick(4);
      sda_low_out = 1'b1;
      tick(4);
      scl_out = 1'b0;
      tick(2);
   endtask

   task automatic bus_stop;
      sda_low_out = 1'b1;
      tick(4);
      scl_out = 1'b1;
      tick(4);
      sda_low_out = 1'b0;
      tick(4);
   endtask

   // Eight bits MSB first, then the ninth slot released; all ones reads and refuses more.
   task automatic put_byte(input logic [7:0] b, output logic [7:0] got);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
         got[i] = s;
      end
      put_bit(1'b1, s);
   endtask

   task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
      logic [7:0] junk;
      bus_start();
      put_byte({dev_addr, 1'b0}, junk);
      put_byte(ofs, junk);
      put_byte(d, junk);
      bus_stop();
   endtask

   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
      logic [7:0] junk;
      bus_start();
      put_byte({dev_addr, 1'b0}, junk);
      put_byte(ofs, junk);
      bus_start();
      put_byte({dev_addr, 1'b1}, junk);
      put_byte(8'hff, d);
      bus_stop();
   endtask
endmodule

`default_nettype wire

// File: spl_splitter_control_registers_bench.sv
`timescale 1ns/10ps
`include "spl_defines.vh"
`default_nettype none

module spl_splitter_control_registers_bench;
   // Compares a seen value with the expected one and counts both outcomes.
   `define SPL_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic mode_pin = 1'b1;
   logic bias_pin = 1'b0;
   logic [3:0] sinks = 4'h5;
   logic [3:0] addr_sel = 4'h9;
   logic [7:0] rd;
   int fails = 0;
   int checks = 0;
   int cycles = 0;
   wire scl_w, host_low, sda_w, sda_drv, sda_oe_n, src_hp, stby, eq_pd, term, pulld, bias_vdd;
   wire [2:0] eq_code;
   wire [3:0] act, dterm, hemph;
   wire [11:0] emph;
   wire [7:0] swing, slew;

   // Open-drain data line with a pull-up.
   assign sda_w = (host_low || (!sda_oe_n && !sda_drv)) ? 1'b0 : 1'b1;

   spl_splitter_control_registers spl_splitter_control_registers_inst (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_w), .sda_in(sda_w), .sda_out_out(sda_drv),
      .sda_oe_n_out(sda_oe_n), .bus_addr_sel_in(addr_sel), .control_mode_select_pin_in(mode_pin),
      .bias_pin_select_in(bias_pin), .sink_plug_detect_input_in(sinks), .source_plug_detect_output_out(src_hp),
      .standby_out(stby), .rx_eq_power_down_out(eq_pd), .rx_term_enable_out(term),
      .rx_pulldown_connect_out(pulld), .rx_bias_vdd_out(bias_vdd), .rx_eq_code_out(eq_code),
      .port_active_out(act), .port_double_term_out(dterm), .port_emph_out(emph), .port_high_emph_out(hemph),
      .port_swing_out(swing), .port_slew_out(slew)
   );

   spl_host_model spl_host_model_inst (
      .clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_w), .sda_low_out(host_low)
   );

   // Free-running 50 MHz clock.
   initial begin
      forever #10 clk_in = ~clk_in;
   end

   // Cuts a hang short well beyond the expected run length.
   always @(negedge clk_in) begin
      cycles++;
      if (cycles >= 40000) begin
         fails++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      spl_host_model_inst.write_reg(o, d);
      tick(4);
   endtask

   task automatic rdr(input logic [7:0] o);
      spl_host_model_inst.read_reg(o, rd);
   endtask

   // Power-up values of every byte and one unmapped offset.
   task automatic t_reset_values;
      logic [7:0] exp [0:8];
      exp = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++) begin
         rdr(8'(i));
         `SPL_CHK("power-up byte", exp[i], rd)
      end
   endtask

   // Connection detector gating and port enables.
   task automatic t_detect;
      `SPL_CHK("active", 4'h5, act)
      `SPL_CHK("termination", 1'b1, term)
      sinks = 4'h0;
      tick(4);
      `SPL_CHK("termination", 1'b0, term)
      `SPL_CHK("active", 4'h0, act)
      wr(8'h00, 8'hfb);
      `SPL_CHK("active", 4'hf, act)
      `SPL_CHK("termination", 1'b1, term)
      wr(8'h00, 8'ha8);
      `SPL_CHK("active", 4'ha, act)
      wr(8'h00, 8'hff);
      sinks = 4'h5;
   endtask

   // Receiver byte: pull-downs, bias and every equalizer code.
   task automatic t_rx;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         // The pin always disagrees, so only register control gives a match.
         bias_pin = !i[0];
         v = {1'b1, i[0], 1'b1, i[2:0], 2'b00};
         wr(8'h01, v);
         `SPL_CHK("pull-down", 1'b0, pulld)
         `SPL_CHK("bias", i[0], bias_vdd)
         `SPL_CHK("eq code", i[2:0], eq_code)
      end
      bias_pin = 1'b1;
      wr(8'h01, 8'h00);
      `SPL_CHK("bias", 1'b1, bias_vdd)
      `SPL_CHK("pull-down", 1'b1, pulld)
      bias_pin = 1'b0;
      tick(4);
      `SPL_CHK("bias", 1'b0, bias_vdd)
   endtask

   // Port bytes with every emphasis code spread over the four ports.
   task automatic t_ports;
      logic [7:0] v;
      int p;
      for (int i = 0; i < 8; i++) begin
         p = i % 4;
         v = {i[0], i[2:0], i[1:0], ~i[1:0]};
         wr(8'h02 + 8'(p), v);
         rdr(8'h02 + 8'(p));
         `SPL_CHK("port byte", v, rd)
         `SPL_CHK("double term", v[7], dterm[p])
         `SPL_CHK("emphasis", v[6:4], emph[p*3 +: 3])
         `SPL_CHK("strong emphasis", v[6], hemph[p])
         `SPL_CHK("swing", v[3:2], swing[p*2 +: 2])
         `SPL_CHK("slew", v[1:0], slew[p*2 +: 2])
      end
   endtask

   // Standby, then the mode pin overriding stored fields.
   task automatic t_pin_mode;
      wr(8'h00, 8'h7f);
      `SPL_CHK("standby", 1'b1, stby)
      `SPL_CHK("eq power-down", 1'b1, eq_pd)
      `SPL_CHK("active", 4'h0, act)
      wr(8'h01, 8'hff);
      mode_pin = 1'b0;
      tick(4);
      `SPL_CHK("standby", 1'b0, stby)
      `SPL_CHK("eq code", 3'h0, eq_code)
      rdr(8'h00);
      `SPL_CHK("stored config", 8'h7f, rd)
      mode_pin = 1'b1;
      tick(4);
      `SPL_CHK("standby", 1'b1, stby)
      wr(8'h00, 8'hff);
      wr(8'h01, 8'h00);
   endtask

   // Hot-plug polarity, read-only bits, foreign address and reserved byte.
   task automatic t_hot_plug;
      wr(8'h06, 8'hff);
      rdr(8'h06);
      `SPL_CHK("hot-plug byte", 8'h85, rd)
      sinks = 4'h2;
      tick(4);
      `SPL_CHK("source plug", 1'b0, src_hp)
      sinks = 4'h0;
      tick(4);
      `SPL_CHK("source plug", 1'b1, src_hp)
      spl_host_model_inst.dev_addr = 7'h50;
      wr(8'h06, 8'h00);
      spl_host_model_inst.dev_addr = {`SPL_DEV_ADDR_HI, 4'h9};
      `SPL_CHK("source plug", 1'b1, src_hp)
      wr(8'h06, 8'h00);
      `SPL_CHK("source plug", 1'b0, src_hp)
      sinks = 4'h8;
      tick(4);
      `SPL_CHK("source plug", 1'b1, src_hp)
      rdr(8'h06);
      `SPL_CHK("hot-plug byte", 8'h08, rd)
      wr(8'h07, 8'h5a);
      rdr(8'h07);
      `SPL_CHK("reserved byte", 8'h00, rd)
   endtask

   // Main sequence.
   initial begin
      repeat (16) @(negedge clk_in);
      reset_n_in = 1'b1;
      tick(2);
      t_reset_values();
      t_detect();
      t_rx();
      t_ports();
      t_pin_mode();
      t_hot_plug();
      end_sim();
   end
endmodule

`default_nettype wire
